// file: sof_cfg.svh
// constants for the serial output formatter
`ifndef SOF_CFG_SVH
`define SOF_CFG_SVH
`define SOF_RESULT_W     32
`define SOF_WLEN_MIN     6'h08
`define SOF_WLEN_MAX     6'h20
`define SOF_DIV_MIN      6'h01
`define SOF_DIV_MAX      6'h20
`define SOF_RES_MSB      31
`define SOF_WLEN_RST     6'h18
`define SOF_DIV_RST      6'h02
// apb register byte addresses
`define SOF_ADDR_CTRL    12'h000
`define SOF_ADDR_TIMING  12'h004
`define SOF_ADDR_STATUS  12'h008
// control register fields
`define SOF_CTRL_WLEN_LSB 0
`define SOF_CTRL_LSBF    8
`define SOF_CTRL_RND     9
`define SOF_CTRL_OFFB    10
`define SOF_CTRL_SCALE   11
`define SOF_CTRL_EN      12
// status register fields
`define SOF_STAT_BUSY    0
`define SOF_STAT_PEND    1
`define SOF_STAT_OVR     2
`endif

// file: sof_formatter.sv
// serial output formatter: parallel result to framed serial stream with divided bit clock
//
// Summary of operation
// - each result is shifted out as a word of 8 to 32 programmable bits
// - control bit picks msb-first or lsb-first shifting
// - control bit picks rounding or truncation to the word length
// - control bit picks two's complement or offset binary coding
// - scale option doubles the value before formatting
// - data changes in step with the generated bit clock
// - bit period is 1 to 32 filter clocks, programmable; the bit clock period is 2 to 32
// - even divide gives exactly half high and half low
// - odd divide n above 1 gives (n+1)/2 high and (n-1)/2 low; n=1 gives one high and one low
// - sync high for one bit period right before first bit
// - fractional weighting; short words use the top result bits
`include "sof_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module sof_formatter
   import sof_pkg::*;
(
   input  wire logic        I_CLK,
   input  wire logic        I_RST_N,
   input  wire logic        I_CE,
   input  wire logic [31:0] I_RESULT,
   input  wire logic        I_RESULT_VALID,
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [11:0] I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic      [31:0] O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   output logic             O_SERIAL_BIT_CLOCK_OUT,
   output logic             O_SERIAL_DATA_OUT,
   output logic             O_WORD_SYNC_OUT
);

   // clamp a programmed 6-bit value into [lo,hi]
   function automatic sof_cnt_t clamp6(input sof_cnt_t v, input sof_cnt_t lo, input sof_cnt_t hi);
      clamp6 = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   // shift the top-aligned word down so its lsb sits at bit 0
   function automatic logic [31:0] pend_pick(input logic [31:0] w, input logic [5:0] wl);
      pend_pick = w >> (6'd32 - wl);
   endfunction

   logic [5:0]  wlen_r;
   logic        lsb_first_r;
   logic        round_r;
   logic        offset_bin_r;
   logic        scale2_r;
   logic        enable_r;
   logic [5:0]  div_r;
   logic        overrun_r;
   logic        pend_r;
   logic [31:0] pend_word_r;
   logic [31:0] shreg_r;
   logic [5:0]  bitcnt_r;
   logic [5:0]  phase_r;
   logic [5:0]  div_nxt;
   logic [5:0]  wlen_nxt;
   logic [5:0]  high_len;
   logic        bit_tick;
   logic [31:0] fmt_word;
   sof_state_e  state_r;

   wire apb_acc = I_PSEL & I_PENABLE;
   wire apb_wr  = apb_acc & I_PWRITE;
   wire decode_ok = (I_PADDR == `SOF_ADDR_CTRL) | (I_PADDR == `SOF_ADDR_TIMING) | (I_PADDR == `SOF_ADDR_STATUS);

   // programmed values kept in range so counters never run away
   assign wlen_nxt = clamp6(I_PWDATA[5:0], `SOF_WLEN_MIN, `SOF_WLEN_MAX);
   assign div_nxt  = clamp6(I_PWDATA[5:0], `SOF_DIV_MIN, `SOF_DIV_MAX);

   // register writes; settings changed mid-word act at once, software should idle first
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         wlen_r       <= `SOF_WLEN_RST;
         lsb_first_r  <= 1'b0;
         round_r      <= 1'b0;
         offset_bin_r <= 1'b0;
         scale2_r     <= 1'b0;
         enable_r     <= 1'b0;
         div_r        <= `SOF_DIV_RST;
      end else if (I_CE && apb_wr && O_PREADY) begin
         if (I_PADDR == `SOF_ADDR_CTRL) begin
            wlen_r       <= wlen_nxt;
            lsb_first_r  <= I_PWDATA[`SOF_CTRL_LSBF];
            round_r      <= I_PWDATA[`SOF_CTRL_RND];
            offset_bin_r <= I_PWDATA[`SOF_CTRL_OFFB];
            scale2_r     <= I_PWDATA[`SOF_CTRL_SCALE];
            enable_r     <= I_PWDATA[`SOF_CTRL_EN];
         end
         if (I_PADDR == `SOF_ADDR_TIMING) begin
            div_r <= div_nxt;
         end
      end
   end

   // apb answer: one wait state, so pready rises the cycle after the access phase starts
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_PREADY  <= 1'b0;
         O_PSLVERR <= 1'b0;
         O_PRDATA  <= 32'h0000_0000;
      end else if (I_CE) begin
         O_PREADY  <= apb_acc & ~O_PREADY;
         O_PSLVERR <= apb_acc & ~O_PREADY & ~decode_ok;
         O_PRDATA  <= 32'h0000_0000;
         if (apb_acc && !O_PREADY && !I_PWRITE) begin
            case (I_PADDR)
               `SOF_ADDR_CTRL:   O_PRDATA <= {19'h0_0000, enable_r, scale2_r, offset_bin_r, round_r,
                                              lsb_first_r, 2'b00, wlen_r};
               `SOF_ADDR_TIMING: O_PRDATA <= {26'h000_0000, div_r};
               `SOF_ADDR_STATUS: O_PRDATA <= {29'h0000_0000, overrun_r, pend_r, (state_r != SOF_IDLE)};
               default:          O_PRDATA <= 32'h0000_0000;
            endcase
         end
      end
   end

   // formatting: scale, round or truncate, saturate on wrap, then code
   function automatic logic [31:0] format_word(input logic [31:0] r, input logic [5:0] wl,
                                               input logic sc, input logic rn, input logic ob);
      logic [33:0] v;
      logic [33:0] half;
      logic [33:0] mask;
      logic [31:0] w;
      v    = {{2{r[31]}}, r};
      half = 34'h0_0000_0000;
      mask = 34'h3_FFFF_FFFF;
      w    = 32'h0000_0000;
      if (sc) v = {v[32:0], 1'b0};
      if (wl < 6'd32) begin
         half = 34'h0_8000_0000 >> wl;
         mask = ~((34'h1_0000_0000 >> wl) - 34'h0_0000_0001);
      end
      if (rn) v = v + half;
      v = v & mask;
      // saturate when scaling or rounding overflows the fractional range
      if (v[33:31] == 3'b001 || v[33:31] == 3'b010 || v[33:31] == 3'b011) w = 32'h7FFF_FFFF & mask[31:0];
      else if (v[33:31] == 3'b100 || v[33:31] == 3'b101 || v[33:31] == 3'b110) w = 32'h8000_0000;
      else w = v[31:0];
      if (ob) w[31] = ~w[31];
      format_word = w;
   endfunction

   assign fmt_word = format_word(I_RESULT, wlen_r, scale2_r, round_r, offset_bin_r);

   // clock divider; high for ceil(n/2), low for floor(n/2) when n>1, runs freely
   assign high_len = 6'((div_r + 6'd1) >> 1);
   assign bit_tick = (phase_r == div_r - 6'd1);
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         phase_r                <= 6'h00;
         O_SERIAL_BIT_CLOCK_OUT <= 1'b0;
      end else if (I_CE) begin
         phase_r <= bit_tick ? 6'h00 : 6'(phase_r + 6'd1);
         // next phase value decides the level, so the clock flop rises on the period boundary
         if (div_r == 6'd1) O_SERIAL_BIT_CLOCK_OUT <= ~O_SERIAL_BIT_CLOCK_OUT; // n=1: toggles every filter clock, half the filter clock rate
         else O_SERIAL_BIT_CLOCK_OUT <= (bit_tick ? 6'h00 : 6'(phase_r + 6'd1)) < high_len;
      end
   end

   // slot handed to the sequencer this cycle; a result then is no overrun, the old word is taken
   wire take_slot = bit_tick && (state_r == SOF_IDLE);
   wire ovr_event = I_RESULT_VALID && enable_r && pend_r && !take_slot;

   // one-word holding slot: a result arriving while busy waits; a second one is an overrun
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         pend_r      <= 1'b0;
         pend_word_r <= 32'h0000_0000;
         overrun_r   <= 1'b0;
      end else if (I_CE) begin
         if (I_RESULT_VALID && enable_r) begin
            pend_word_r <= fmt_word;
            pend_r      <= 1'b1;
            overrun_r   <= overrun_r | ovr_event;
         end else if (take_slot) begin
            pend_r <= 1'b0;
         end
         // clearing by status write; a new overrun the same cycle wins
         if (apb_wr && O_PREADY && I_PADDR == `SOF_ADDR_STATUS && I_PWDATA[`SOF_STAT_OVR] && !ovr_event)
            overrun_r <= 1'b0;
      end
   end

   // word sequencer; outputs change only at bit period boundaries
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         state_r           <= SOF_IDLE;
         shreg_r           <= 32'h0000_0000;
         bitcnt_r          <= 6'h00;
         O_SERIAL_DATA_OUT <= 1'b0;
         O_WORD_SYNC_OUT   <= 1'b0;
      end else if (I_CE && bit_tick) begin
         case (state_r)
            SOF_IDLE: begin
               O_SERIAL_DATA_OUT <= 1'b0;
               O_WORD_SYNC_OUT   <= pend_r;
               if (pend_r) begin
                  // lsb-first words are realigned so bit 0 of shreg is the word's lsb
                  shreg_r <= lsb_first_r ? (pend_pick(pend_word_r, wlen_r)) : pend_word_r;
                  state_r <= SOF_SYNC;
               end
            end
            SOF_SYNC, SOF_DATA: begin
               O_WORD_SYNC_OUT   <= 1'b0;
               O_SERIAL_DATA_OUT <= lsb_first_r ? shreg_r[0] : shreg_r[31];
               shreg_r           <= lsb_first_r ? {1'b0, shreg_r[31:1]} : {shreg_r[30:0], 1'b0};
               bitcnt_r          <= (state_r == SOF_SYNC) ? 6'd1 : 6'(bitcnt_r + 6'd1);
               state_r           <= SOF_DATA;
               if (state_r == SOF_DATA && bitcnt_r == wlen_r) begin
                  state_r           <= SOF_IDLE;
                  O_SERIAL_DATA_OUT <= 1'b0;
               end
            end
            default: state_r <= SOF_IDLE;
         endcase
      end
   end

   // named steps of a word: the idle tick that starts it, the sync tick, the tick that ends it
   sequence s_word_start;
      I_CE && bit_tick && state_r == SOF_IDLE && pend_r;
   endsequence
   sequence s_sync_tick;
      I_CE && bit_tick && state_r == SOF_SYNC;
   endsequence
   sequence s_last_tick;
      I_CE && bit_tick && state_r == SOF_DATA && bitcnt_r == wlen_r;
   endsequence
   sequence s_sync_out;
      O_WORD_SYNC_OUT && !O_SERIAL_DATA_OUT && state_r == SOF_SYNC;
   endsequence

   // checker helpers: cycles since the last tick, and a divide change seen since then
   logic [5:0] chk_gap_r;
   logic [5:0] chk_div_q_r;
   logic       chk_div_chg_r;
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         chk_gap_r     <= 6'h00;
         chk_div_q_r   <= `SOF_DIV_RST;
         chk_div_chg_r <= 1'b1;
      end else if (I_CE) begin
         chk_gap_r     <= bit_tick ? 6'h00 : 6'(chk_gap_r + 6'd1);
         chk_div_q_r   <= div_r;
         chk_div_chg_r <= bit_tick ? 1'b0 : (chk_div_chg_r | (div_r != chk_div_q_r));
      end
   end

   // sync lasts exactly one bit period and is followed by data
   AST_SYNC_START: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      s_word_start |=> s_sync_out)
      else $error("pending word did not raise sync");
   AST_SYNC_ONE_PERIOD: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (I_CE && bit_tick && O_WORD_SYNC_OUT) |=> !O_WORD_SYNC_OUT || !I_CE)
      else $error("sync held longer than one bit period");
   AST_SYNC_THEN_DATA: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (I_CE && bit_tick && state_r == SOF_SYNC) |=> (state_r == SOF_DATA || !I_CE))
      else $error("first bit did not follow sync");
   AST_DIV_PERIOD: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (I_CE && bit_tick && !chk_div_chg_r && div_r == chk_div_q_r) |-> chk_gap_r == 6'(div_r - 6'd1))
      else $error("divider period wrong");
   // the level was chosen with the old divide in the cycle right after a change
   AST_HIGH_SPAN: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (div_r > 6'd1 && I_CE && $stable(div_r) && phase_r < high_len && phase_r != 6'd0)
      |-> O_SERIAL_BIT_CLOCK_OUT)
      else $error("bit clock low during high span");
   AST_LOW_SPAN: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (div_r > 6'd1 && $stable(div_r) && phase_r >= high_len) |-> !O_SERIAL_BIT_CLOCK_OUT)
      else $error("bit clock high during low span");
   AST_DATA_ON_TICK: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (!(I_CE && $past(bit_tick)) && $past(I_RST_N)) |-> $stable(O_SERIAL_DATA_OUT))
      else $error("data moved off the bit clock boundary");
   AST_IDLE_QUIET: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (state_r == SOF_IDLE && $past(state_r) == SOF_IDLE) |-> !O_SERIAL_DATA_OUT)
      else $error("data not idle between words");
   AST_WORD_LEN: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (state_r == SOF_DATA) |-> bitcnt_r <= wlen_r && wlen_r >= `SOF_WLEN_MIN)
      else $error("word ran past its length");
   AST_OFFSET_SIGN: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (I_RESULT_VALID && offset_bin_r && !round_r && !scale2_r) |->
      fmt_word[31] == ~I_RESULT[31] &&
      fmt_word[30:0] == (I_RESULT[30:0] & (~(31'h7FFF_FFFF >> (wlen_r - 6'd1)))))
      else $error("offset binary coding wrong");
   AST_SCALE: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (I_RESULT_VALID && scale2_r && !round_r && !offset_bin_r && wlen_r == 6'd32 &&
       I_RESULT[31] == I_RESULT[30]) |-> fmt_word == {I_RESULT[30:0], 1'b0})
      else $error("scale by two wrong");

   // truncation keeps the top word bits; rounding adds the first dropped bit
   AST_TRUNC: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (I_RESULT_VALID && !round_r && !scale2_r && !offset_bin_r) |-> fmt_word == (I_RESULT & ~(32'hFFFF_FFFF >> wlen_r)))
      else $error("truncated word wrong");
   AST_ROUND8: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (I_RESULT_VALID && round_r && !scale2_r && !offset_bin_r && wlen_r == 6'd8 && I_RESULT[31:23] != 9'h0FF)
      |-> fmt_word == {8'(I_RESULT[31:24] + {7'h00, I_RESULT[23]}), 24'h00_0000})
      else $error("rounded word wrong");

   // first bit after sync comes from the chosen end of the word
   AST_FIRST_BIT_MSB: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      s_sync_tick ##0 !lsb_first_r |=> O_SERIAL_DATA_OUT == $past(shreg_r[31]) && bitcnt_r == 6'd1)
      else $error("msb-first word began with the wrong bit");
   AST_FIRST_BIT_LSB: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      s_sync_tick ##0 lsb_first_r |=> O_SERIAL_DATA_OUT == $past(shreg_r[0]) && bitcnt_r == 6'd1)
      else $error("lsb-first word began with the wrong bit");

   // word ends after its last bit, and the line stays quiet while nothing waits
   AST_WORD_END: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      s_last_tick |=> state_r == SOF_IDLE && !O_SERIAL_DATA_OUT && !O_WORD_SYNC_OUT)
      else $error("word did not end on its length");
   AST_SYNC_QUIET_IDLE: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (I_CE && bit_tick && state_r == SOF_IDLE && !pend_r) |=> !O_WORD_SYNC_OUT && !O_SERIAL_DATA_OUT)
      else $error("sync or data raised with nothing pending");
   AST_CLK_RISE_ON_TICK: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (I_CE && bit_tick && div_r > 6'd1) |=> O_SERIAL_BIT_CLOCK_OUT)
      else $error("bit clock not high when data changed");

   // holding slot: results only while enabled; a second result while one waits flags overrun
   AST_PEND_TAKEN: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (I_CE && I_RESULT_VALID && enable_r) |=> pend_r)
      else $error("result not held");
   AST_IGNORE_DISABLED: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (I_CE && !enable_r && !pend_r) |=> !pend_r)
      else $error("result taken while disabled");
   AST_OVR_SET_WINS: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (I_CE && I_RESULT_VALID && enable_r && pend_r && !(bit_tick && state_r == SOF_IDLE)) |=> overrun_r)
      else $error("overrun not flagged");

   // bus answer: exactly one wait state and a one-cycle ready
   AST_APB_ONE_WAIT: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (I_CE && I_PSEL && I_PENABLE && !O_PREADY) |=> O_PREADY)
      else $error("ready did not follow the access phase");
   AST_APB_READY_PULSE: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (I_CE && O_PREADY) |=> !O_PREADY)
      else $error("ready held longer than one cycle");

endmodule // sof_formatter
`default_nettype wire

// file: sof_formatter_tb_top.sv
// self-checking bench for the serial output formatter
`include "sof_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module sof_formatter_tb_top;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, res_vld, bclk, sdata, sync, last_b;
   logic        ce;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, res, rx_word;
   logic [5:0]  rx_cnt;
   int          bad_count = 0;
   int          cmp_count = 0;
   // per word: control, divide, result, length, expected received word, clock high and low
   logic [31:0] t_ctrl [6] = '{32'h0000_1018, 32'h0000_1508, 32'h0000_1208, 32'h0000_1810, 32'h0000_1020,
                               32'h0000_1820};
   logic [31:0] t_tim [6] = '{32'h0000_0002, 32'h0000_0003, 32'h0000_0004, 32'h0000_0005, 32'h0000_0020,
                              32'h0000_0002};
   logic [31:0] t_res [6] = '{32'h1234_5680, 32'h8100_0000, 32'h1280_0000, 32'h1234_0000, 32'ha5c3_0f01,
                              32'h1234_5678};
   logic [31:0] t_n [6] = '{32'h0000_0018, 32'h0000_0008, 32'h0000_0008, 32'h0000_0010, 32'h0000_0020,
                            32'h0000_0020};
   logic [31:0] t_exp [6] = '{32'h0012_3456, 32'h0000_0080, 32'h0000_0013, 32'h0000_2468, 32'ha5c3_0f01,
                              32'h2468_acf0};
   logic [31:0] t_hi [6] = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0002, 32'h0000_0003, 32'h0000_0010,
                             32'h0000_0001};
   logic [31:0] t_lo [6] = '{32'h0000_0001, 32'h0000_0001, 32'h0000_0002, 32'h0000_0002, 32'h0000_0010,
                             32'h0000_0001};

   sof_formatter uut (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_RESULT(res), .I_RESULT_VALID(res_vld),
      .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
      .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .O_SERIAL_BIT_CLOCK_OUT(bclk),
      .O_SERIAL_DATA_OUT(sdata), .O_WORD_SYNC_OUT(sync));
   sof_rx_model rx (.i_clk(clk), .i_rst_n(rst_n), .i_bclk(bclk), .i_data(sdata), .i_sync(sync),
      .o_word(rx_word), .o_cnt(rx_cnt));

   // 10 MHz filter clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // bit clock one edge back, to spot its rises
   always @(posedge clk) last_b <= bclk;

   task test_done;
      $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task tmo;
      bad_count++;
      $display("unexpected wait ran out");
      test_done();
   endtask
   // apb transfer held until pready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      q = prdata;
      e = pslverr;
      if (k == 20) tmo();
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task push(input logic [31:0] v, input int n);
      @(posedge clk);
      res <= v;
      res_vld <= 1'b1;
      repeat (n) @(posedge clk);
      res_vld <= 1'b0;
   endtask
   task s_reset;
      logic [31:0] q;
      logic e, seen;
      chk("outputs after reset", {29'h0, bclk, sdata, sync}, 32'h0);
      apb(1'b0, `SOF_ADDR_CTRL, 32'h0, q, e);
      chk("ctrl reset", q, 32'h0000_0018);
      apb(1'b0, `SOF_ADDR_TIMING, 32'h0, q, e);
      chk("timing reset", q, 32'h0000_0002);
      apb(1'b0, 12'h00c, 32'h0, q, e);
      chk("unmapped error", {31'h0, e}, 32'h1);
      push(32'h7fff_ffff, 1);
      seen = 1'b0;
      repeat (60) begin
         @(posedge clk);
         seen = seen | sync;
      end
      chk("sync while disabled", {31'h0, seen}, 32'h0);
   endtask
   // one word: clock shape, framing, formatting, then idle line
   task word(input int i);
      logic [31:0] q;
      logic e;
      int k, hi, lo;
      apb(1'b1, `SOF_ADDR_TIMING, t_tim[i], q, e);
      apb(1'b1, `SOF_ADDR_CTRL, t_ctrl[i], q, e);
      push(t_res[i], 1);
      for (k = 0; k < 300 && sync !== 1'b1; k++) @(posedge clk);
      if (k == 300) tmo();
      hi = 1;
      lo = 0;
      for (k = 0; k < 40; k++) begin
         @(posedge clk);
         if (bclk !== 1'b1) break;
         hi++;
      end
      for (k = 0; k < 40 && bclk === 1'b0; k++) begin
         lo++;
         @(posedge clk);
      end
      chk("clock high", 32'(hi), t_hi[i]);
      chk("clock low", 32'(lo), t_lo[i]);
      for (k = 0; k < 2000 && rx_cnt !== t_n[i][5:0]; k++) @(posedge clk);
      if (k == 2000) tmo();
      chk("word", rx_word & ~(32'hffff_ffff << t_n[i]), t_exp[i]);
      for (k = 0; k < 80 && !(bclk === 1'b1 && last_b === 1'b0); k++) @(posedge clk);
      chk("idle after word", {30'h0, sdata, sync}, 32'h0);
   endtask
   // a burst of results while a word is out raises overrun, cleared by writing one
   task s_ovr;
      logic [31:0] q;
      logic e;
      push(32'h5500_0000, 3);
      apb(1'b0, `SOF_ADDR_STATUS, 32'h0, q, e);
      chk("overrun set", q & 32'h4, 32'h4);
      apb(1'b1, `SOF_ADDR_STATUS, 32'h4, q, e);
      apb(1'b0, `SOF_ADDR_STATUS, 32'h0, q, e);
      chk("overrun cleared", q & 32'h4, 32'h0);
   endtask
   // clock enable low mid-word must freeze the link outputs
   task s_freeze;
      logic [2:0] held;
      logic       moved;
      @(posedge clk);
      ce <= 1'b0;
      @(posedge clk);
      held = {bclk, sdata, sync};
      moved = 1'b0;
      repeat (20) begin
         @(posedge clk);
         moved = moved | ({bclk, sdata, sync} !== held);
      end
      ce <= 1'b1;
      chk("outputs frozen", {31'h0, moved}, 32'h0);
   endtask

   initial begin
      {rst_n, psel, penable, pwrite, res_vld} = 5'h0;
      ce = 1'b1;
      paddr = 12'h000;
      pwdata = 32'h0;
      res = 32'h0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      s_reset();
      for (int i = 0; i < 6; i++) word(i);
      s_ovr();
      s_freeze();
      test_done();
   end
endmodule // sof_formatter_tb_top
`default_nettype wire

// file: sof_pkg.sv
// types for the serial output formatter
package sof_pkg;
   typedef enum logic [1:0] {
      SOF_IDLE = 2'b00,
      SOF_SYNC = 2'b01,
      SOF_DATA = 2'b10
   } sof_state_e;
   typedef logic [5:0] sof_cnt_t;
endpackage

// file: sof_rx_model.sv
// receiver model that frames serial words on the sync pulse
`timescale 1ns/1ns
`default_nettype none
module sof_rx_model (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_bclk,
   input  wire logic        i_data,
   input  wire logic        i_sync,
   output logic      [31:0] o_word,
   output logic      [5:0]  o_cnt
);
   logic bclk_r;
   // bits are taken at each bit clock rise without sync, seen one filter clock late; a rise with sync clears the count
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bclk_r <= 1'b0;
         o_word <= 32'h0000_0000;
         o_cnt  <= 6'h00;
      end else begin
         bclk_r <= i_bclk;
         if (i_bclk && !bclk_r && i_sync) begin
            o_cnt <= 6'h00;
         end else if (i_bclk && !bclk_r) begin
            o_word <= {o_word[30:0], i_data};
            o_cnt  <= o_cnt + 6'h01; // count runs on in idle, so callers wait for sync first
         end
      end
   end
endmodule // sof_rx_model
`default_nettype wire
